// file: common/pmr_cfg.svh
// Constants of the programmer-mode read control block.
// Assumes a byte-wide socket bus and a 16-bit flash address.
`ifndef PMR_CFG_SVH
`define PMR_CFG_SVH

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define PMR_CMD_READ   8'h00
`define PMR_CMD_PROG   8'h40
`define PMR_CMD_ERASE  8'h20
`define PMR_CMD_STAT   8'h71

// ----------------------------------------
// Counts and field positions
// ----------------------------------------
`define PMR_PROG_BYTES 128
`define PMR_ST_ABN_BIT 7
`define PMR_ST_CERR_BIT 6
`define PMR_POLL_END_BIT 7
`define PMR_POLL_FAIL_BIT 6
`define PMR_ADDR_W     16
`define PMR_DATA_W     8

`endif

// file: common/pmr_pkg.sv
// Types of the programmer-mode read control block.
// Assumes pmr_cfg.svh is included before this package.
`include "pmr_cfg.svh"

package pmr_pkg;

  // ----------------------------------------
  // Socket pins and auto-operation result
  // ----------------------------------------
  typedef struct packed {
    logic                    flash_write_permit;
    logic                    ce_n;
    logic                    oe_n;
    logic                    we_n;
    logic [`PMR_ADDR_W-1:0]  addr;
    logic [`PMR_DATA_W-1:0]  data;
  } pmr_pins_t;

  typedef struct packed {
    logic done;
    logic fail;
  } pmr_result_t;

  typedef enum logic [2:0] {
    PMR_WAIT   = 3'b000,
    PMR_READ   = 3'b001,
    PMR_PROG   = 3'b010,
    PMR_ERASE  = 3'b011,
    PMR_STATQ  = 3'b100,
    PMR_BUSY   = 3'b101,
    PMR_STATUS = 3'b110
  } pmr_mode_t;

endpackage

// file: core/pmr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/1ps

module pmr_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] filt_r;

  // First stage only feeds the second
  // Reset to the idle level so no false strobe edge follows reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Per bit: take stage two once stage three matches it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      filt_r <= '1;
    end else begin
      filt_r <= (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
    end
  end

  assign pin_out = filt_r;

endmodule // pmr_pin_sync

// file: core/pmr_ctrl.sv
// Programmer-mode command and read control for the on-chip flash.
// Assumes array read data arrives one clock after the address, and an
// auto-operation engine that answers start with a one-cycle done pulse.
//
// Functional notes
// - When an auto-program or auto-erase finishes, go to command wait; status read mode holds until the next command write.
// - In memory read mode any number of reads follow with no further command.
// - In memory read mode command writes decode exactly as in command wait.
// - After power-up the block stands in memory read mode.
// - A memory read is one command write then one read per address presented.
// - Status read mode outputs the kept flags: abnormal end (auto-operation fail or command error) and command error.
`timescale 1ns/1ps
`include "pmr_cfg.svh"

module pmr_ctrl
  import pmr_pkg::*;
#(
  parameter int PROG_BYTES = `PMR_PROG_BYTES
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire pmr_pins_t              pins,
  input  wire logic [`PMR_DATA_W-1:0] mem_rdata,
  input  wire pmr_result_t            op_result,
  output logic [`PMR_DATA_W-1:0]      data_out_r,
  output logic                        data_oe_n_r,
  output logic [`PMR_ADDR_W-1:0]      mem_addr_r,
  output logic                        mem_rd_r,
  output logic                        prog_wr_r,
  output logic [`PMR_ADDR_W-1:0]      prog_addr_r,
  output logic [`PMR_DATA_W-1:0]      prog_data_r,
  output logic                        op_start_r,
  output logic                        op_erase_r,
  output pmr_mode_t                   mode_r
);

  // ----------------------------------------
  // Pin conditioning
  // ----------------------------------------
  pmr_pins_t                pins_f;
  logic                     flag_clr;
  logic                     we_prev_r;
  logic                     wr_ev;
  logic                     rd_act;
  logic [`PMR_DATA_W-1:0]   cmd;
  logic [7:0]               byte_cnt_r;
  logic                     end_r;
  logic                     fail_r;
  logic                     cerr_r;
  pmr_mode_t                mode_nxt;
  logic                     cmd_bad;

  pmr_pin_sync #(.W($bits(pmr_pins_t))) u_sync (
    .clock   (clock),
    .rst_n   (rst_n),
    .pin_in  (pins),
    .pin_out (pins_f)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      we_prev_r <= 1'b1;
    end else begin
      we_prev_r <= pins_f.we_n;
    end
  end

  // Write taken at the rising edge of write enable, data still held there
  assign wr_ev  = !pins_f.ce_n && pins_f.we_n && !we_prev_r;
  assign rd_act = !pins_f.ce_n && !pins_f.oe_n && pins_f.we_n;
  assign cmd    = pins_f.data;

  // ----------------------------------------
  // Mode state
  // ----------------------------------------
  function automatic pmr_mode_t decode_cmd(input logic [`PMR_DATA_W-1:0] c,
                                           input logic permit);
    if (c == `PMR_CMD_READ) begin
      decode_cmd = PMR_READ;
    end else if (c == `PMR_CMD_PROG && permit) begin
      decode_cmd = PMR_PROG;
    end else if (c == `PMR_CMD_ERASE && permit) begin
      decode_cmd = PMR_ERASE;
    end else if (c == `PMR_CMD_STAT) begin
      decode_cmd = PMR_STATQ;
    end else begin
      decode_cmd = PMR_WAIT;
    end
  endfunction

  assign cmd_bad = wr_ev && (mode_r == PMR_WAIT || mode_r == PMR_READ ||
                   mode_r == PMR_STATUS) &&
                   decode_cmd(cmd, pins_f.flash_write_permit) == PMR_WAIT;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PMR_WAIT, PMR_READ, PMR_STATUS: begin
        if (wr_ev) begin
          mode_nxt = decode_cmd(cmd, pins_f.flash_write_permit);
        end
      end
      PMR_PROG: begin
        if (wr_ev && byte_cnt_r == 8'(PROG_BYTES - 1)) begin
          mode_nxt = PMR_BUSY;
        end
      end
      PMR_ERASE: begin
        if (wr_ev) begin
          mode_nxt = (cmd == `PMR_CMD_ERASE) ? PMR_BUSY : PMR_WAIT;
        end
      end
      PMR_STATQ: begin
        if (wr_ev) begin
          mode_nxt = (cmd == `PMR_CMD_STAT) ? PMR_STATUS : PMR_WAIT;
        end
      end
      PMR_BUSY: begin
        if (op_result.done) begin
          mode_nxt = PMR_WAIT;
        end
      end
      default: mode_nxt = PMR_WAIT;
    endcase
  end

  // Power-up lands in memory read so a blank programmer can read at once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= PMR_READ;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------
  // Auto-program byte collection and start
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_r  <= 8'h00;
      prog_wr_r   <= 1'b0;
      prog_addr_r <= '0;
      prog_data_r <= '0;
    end else begin
      prog_wr_r <= mode_r == PMR_PROG && wr_ev;
      if (mode_r != PMR_PROG) begin
        byte_cnt_r <= 8'h00;
      end else if (wr_ev) begin
        byte_cnt_r  <= byte_cnt_r + 8'h01;
        prog_addr_r <= pins_f.addr;
        prog_data_r <= pins_f.data;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_start_r <= 1'b0;
      op_erase_r <= 1'b0;
    end else begin
      op_start_r <= mode_nxt == PMR_BUSY && mode_r != PMR_BUSY;
      if (mode_nxt == PMR_BUSY && mode_r != PMR_BUSY) begin
        op_erase_r <= mode_r == PMR_ERASE;
      end
    end
  end

  // ----------------------------------------
  // Result flags, kept until the next command write
  // ----------------------------------------
  // Status command writes keep the code; writes refused while busy clear nothing
  assign flag_clr = wr_ev && !(mode_r inside {PMR_STATQ, PMR_BUSY}) &&
                    mode_nxt != PMR_STATQ;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      end_r  <= 1'b0;
      fail_r <= 1'b0;
      cerr_r <= 1'b0;
    end else begin
      if (mode_r == PMR_BUSY && op_result.done) begin
        end_r  <= 1'b1;
        fail_r <= op_result.fail;
      end else if (flag_clr) begin
        end_r  <= 1'b0;
        fail_r <= 1'b0;
      end
      // Set wins over clear in the same cycle
      if (cmd_bad || (wr_ev && mode_r inside {PMR_ERASE, PMR_STATQ} &&
          mode_nxt == PMR_WAIT)) begin
        cerr_r <= 1'b1;
      end else if (flag_clr) begin
        cerr_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_r <= '0;
      mem_rd_r   <= 1'b0;
    end else begin
      mem_rd_r <= rd_act && mode_r == PMR_READ;
      if (rd_act && mode_r == PMR_READ) begin
        mem_addr_r <= pins_f.addr;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_out_r  <= '0;
      data_oe_n_r <= 1'b1;
    end else begin
      data_oe_n_r <= !rd_act;
      unique case (mode_r)
        PMR_READ: data_out_r <= mem_rdata;
        PMR_STATUS: begin
          data_out_r                   <= '0;
          data_out_r[`PMR_ST_ABN_BIT]  <= fail_r | cerr_r;
          data_out_r[`PMR_ST_CERR_BIT] <= cerr_r;
        end
        default: begin
          data_out_r                     <= '0;
          data_out_r[`PMR_POLL_END_BIT]  <= end_r;
          data_out_r[`PMR_POLL_FAIL_BIT] <= fail_r | cerr_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_prog_last;
    mode_r == PMR_PROG && wr_ev && byte_cnt_r == 8'(PROG_BYTES - 1);
  endsequence

  sequence s_start_busy;
    op_start_r && !op_erase_r && mode_r == PMR_BUSY;
  endsequence

  a_done_to_wait: assert property (
    mode_r == PMR_BUSY && op_result.done |=> mode_r == PMR_WAIT)
    else $error("auto operation end did not return to command wait");

  a_read_mode_holds: assert property (
    mode_r == PMR_READ && !wr_ev && rd_act [*3] |=> mode_r == PMR_READ)
    else $error("memory read mode left without a command write");

  a_read_decodes: assert property (
    mode_r == PMR_READ && wr_ev && cmd == `PMR_CMD_STAT |=> mode_r == PMR_STATQ)
    else $error("command write in read mode not decoded");

  a_reset_read_mode: assert property (
    @(posedge clock) $rose(rst_n) |-> mode_r == PMR_READ)
    else $error("not in memory read mode after reset");

  a_read_addr_data: assert property (
    mode_r == PMR_READ && rd_act && !wr_ev |=> mem_rd_r &&
    mem_addr_r == $past(pins_f.addr) ##1 data_out_r == $past(mem_rdata))
    else $error("memory read address or data wrong");

  a_status_byte: assert property (
    mode_r == PMR_STATUS ##1 mode_r == PMR_STATUS |->
    data_out_r[`PMR_ST_CERR_BIT] == $past(cerr_r))
    else $error("status byte does not show the command error");

  a_cmd_capture: assert property (
    mode_r == PMR_WAIT && wr_ev && cmd == `PMR_CMD_READ |=> mode_r == PMR_READ)
    else $error("read command not taken on write pulse");

  a_prog_start: assert property (
    s_prog_last |=> s_start_busy)
    else $error("auto program not started after the last byte");

  a_oe_release: assert property (
    !rd_act |=> data_oe_n_r)
    else $error("data driven with no read cycle");

endmodule // pmr_ctrl

// file: testbench/pmr_prog_model.sv
// Socket programmer model: drives the pins of the control block.
// Assumes the bench clock; every pin change lands just after a rising edge.
`timescale 1ns/1ps

module pmr_prog_model
  import pmr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] data_in,
  input  wire logic       data_oe_n,
  output pmr_pins_t       pins
);
  // ----------------------------------------
  // Idle pins
  // ----------------------------------------
  initial begin
    pins = '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000, 8'h00};
  end

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Long holds: the pins pass a slow filter inside the block
  task automatic wr(input logic [7:0] d, input logic [15:0] a, input logic pm);
    @(posedge clock);
    pins.flash_write_permit <= pm;
    pins.addr               <= a;
    pins.data               <= d;
    pins.ce_n               <= 1'b0;
    repeat (6) @(posedge clock);
    pins.we_n <= 1'b0;
    repeat (4) @(posedge clock);
    pins.we_n <= 1'b1;
    repeat (6) @(posedge clock);
    pins.ce_n <= 1'b1;
    // Released bus shows the inverse, never the old byte
    pins.data <= ~d;
    repeat (4) @(posedge clock);
  endtask

  // Reads need a prior read command unless fresh from power-up
  task automatic rd(input logic [15:0] a, output logic [7:0] q, output logic oe_n);
    @(posedge clock);
    pins.addr <= a;
    pins.ce_n <= 1'b0;
    pins.oe_n <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
    q    = data_in;
    oe_n = data_oe_n;
    @(posedge clock);
    pins.ce_n <= 1'b1;
    pins.oe_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
endmodule // pmr_prog_model

// file: testbench/tb.sv
// Self-checking bench of the programmer-mode read control.
// Assumes a flash array and auto-op engine modelled here.
`timescale 1ns/1ps

module tb;
  import pmr_pkg::*;
  localparam int NB = 4;

  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [3:0] n;
    logic       pm;
    logic       fl;
    pmr_mode_t  md;
    logic       ck;
    logic [7:0] q;
  } pmr_row_t;

  logic        clock;
  logic        rst_n;
  pmr_pins_t   pins;
  logic [7:0]  mem_rdata;
  pmr_result_t op_result;
  logic [7:0]  data_out_r;
  logic        data_oe_n_r;
  logic [15:0] mem_addr_r;
  logic        mem_rd_r;
  logic        prog_wr_r;
  logic [15:0] prog_addr_r;
  logic [7:0]  prog_data_r;
  logic        op_start_r;
  logic        op_erase_r;
  pmr_mode_t   mode_r;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  int          n_prog = 0;
  int          busy_cnt = 0;
  logic        fail_sel;
  logic [7:0]  q;
  logic        oe;

  pmr_row_t rows [9] = '{
    '{8'h00, 8'h00, 4'd1, 1'b1, 1'b0, PMR_READ, 1'b1, 8'h03},
    '{8'h20, 8'h20, 4'd2, 1'b1, 1'b1, PMR_WAIT, 1'b1, 8'hc0},
    '{8'h00, 8'h00, 4'd1, 1'b1, 1'b0, PMR_READ, 1'b1, 8'h03},
    '{8'h40, 8'ha5, 4'(NB + 1), 1'b1, 1'b0, PMR_WAIT, 1'b1, 8'h80},
    '{8'h20, 8'h20, 4'd1, 1'b0, 1'b0, PMR_WAIT, 1'b1, 8'h40},
    '{8'h71, 8'h71, 4'd2, 1'b1, 1'b0, PMR_STATUS, 1'b1, 8'hc0},
    '{8'h00, 8'h00, 4'd1, 1'b1, 1'b0, PMR_READ, 1'b1, 8'h03},
    '{8'h71, 8'h20, 4'd2, 1'b1, 1'b0, PMR_WAIT, 1'b1, 8'h40},
    '{8'h20, 8'h00, 4'd2, 1'b1, 1'b0, PMR_WAIT, 1'b1, 8'h40}
  };

  pmr_ctrl #(.PROG_BYTES(NB)) u_pmr_ctrl (
    .clock(clock), .rst_n(rst_n), .pins(pins), .mem_rdata(mem_rdata),
    .op_result(op_result), .data_out_r(data_out_r), .data_oe_n_r(data_oe_n_r),
    .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r), .prog_wr_r(prog_wr_r),
    .prog_addr_r(prog_addr_r), .prog_data_r(prog_data_r), .op_start_r(op_start_r),
    .op_erase_r(op_erase_r), .mode_r(mode_r)
  );

  pmr_prog_model u_pmr_prog_model (
    .clock(clock), .data_in(data_out_r), .data_oe_n(data_oe_n_r), .pins(pins)
  );

  // ----------------------------------------
  // Array, engine and timeout
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Engine slow enough that a write fits inside its busy time
  always @(posedge clock) begin
    mem_rdata <= mem_addr_r[15:8] ^ mem_addr_r[7:0];
    op_result <= '0;
    if (op_start_r) busy_cnt <= 40;
    else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    if (busy_cnt == 1) op_result <= '{1'b1, fail_sel};
    if (prog_wr_r) n_prog <= n_prog + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    for (int t = 0; t < 100 && mode_r === PMR_BUSY; t++) @(posedge clock);
    #1;
  endtask

  task automatic reads();
    logic [15:0] a [3] = '{16'h1234, 16'hff00, 16'h00aa};
    for (int i = 0; i < 3; i++) begin
      u_pmr_prog_model.rd(a[i], q, oe);
      chk(16'(q), 16'(a[i][15:8] ^ a[i][7:0]));
      chk(16'(oe), 16'h0000);
      chk(mem_addr_r, a[i]);
      chk(16'(mem_rd_r), 16'h0001);
    end
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rst_n     = 1'b0;
    fail_sel  = 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk(16'(mode_r), 16'(PMR_READ));
    @(posedge clock);
    rst_n <= 1'b1;
    reads();
    foreach (rows[i]) begin
      fail_sel = rows[i].fl;
      u_pmr_prog_model.wr(rows[i].c1, 16'h0000, rows[i].pm);
      for (int k = 1; k < rows[i].n; k++)
        u_pmr_prog_model.wr(rows[i].c2, 16'h0080 + 16'(k), rows[i].pm);
      settle();
      chk(16'(mode_r), 16'(rows[i].md));
      if (rows[i].ck) begin
        u_pmr_prog_model.rd(16'h0102, q, oe);
        chk(16'(q), 16'(rows[i].q));
      end
    end
    chk(16'(n_prog), 16'(NB));
    chk(16'(prog_data_r), 16'h00a5);
    chk(prog_addr_r, 16'h0084);
    chk(16'(op_erase_r), 16'h0000);
    // Writes while the engine runs are dropped
    u_pmr_prog_model.wr(8'h20, 16'h0000, 1'b1);
    u_pmr_prog_model.wr(8'h20, 16'h0000, 1'b1);
    #1;
    chk(16'(mode_r), 16'(PMR_BUSY));
    chk(16'(op_erase_r), 16'h0001);
    u_pmr_prog_model.wr(8'h00, 16'h0000, 1'b1);
    #1;
    chk(16'(mode_r), 16'(PMR_BUSY));
    settle();
    chk(16'(mode_r), 16'(PMR_WAIT));
    // Second reset from command wait
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk(16'(mode_r), 16'(PMR_READ));
    chk(16'(data_oe_n_r), 16'h0001);
    @(posedge clock);
    rst_n <= 1'b1;
    reads();
    give_verdict();
  end
endmodule // tb
